// >>> verilog/fpd_tx_pkg.sv
package fpd_tx_pkg;

  localparam int LANES = 4;
  localparam int SLOTS = 7;
  localparam int WORD_BITS = 28;
  localparam int MAP_W = 5;
  localparam int FIFO_DEPTH = 16;
  // Core cycles per bit slot
  localparam int SLOT_DIV = 4;

  localparam int CLK_PERIOD_NS = 5;
  localparam int PDD_TIME_NS = 100;
  localparam int PDD_CYCLES = (PDD_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : PDD_TIME_NS / CLK_PERIOD_NS;
  localparam int LOCK_TIME_MS = 10;
  localparam int LOCK_CYCLES = LOCK_TIME_MS * 1_000_000 / CLK_PERIOD_NS;

  // Slots 0..3 high, 4..6 low
  localparam logic [SLOTS-1:0] CLK_PATTERN = 7'h0f;

  typedef enum logic [2:0] {
    ST_DOWN = 3'h1,
    ST_LOCK = 3'h2,
    ST_RUN  = 3'h4
  } tx_state_e;

  typedef struct packed {
    logic spare;
    logic pixel_valid;
    logic frame_sync;
    logic line_sync;
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
  } pixel_word_s;

  typedef struct packed {
    logic [LANES-1:0] serial_lane_p;
    logic [LANES-1:0] serial_lane_n;
    logic forwarded_clock_p;
    logic forwarded_clock_n;
  } serial_link_s;

  // Entry lane*SLOTS+slot names the input bit sent there
  typedef logic [LANES*SLOTS-1:0][MAP_W-1:0] lane_map_t;

  function automatic lane_map_t default_map();
    lane_map_t m;
    for (int i = 0; i < LANES * SLOTS; i++) begin
      m[i] = MAP_W'(i);
    end
    return m;
  endfunction : default_map

  localparam lane_map_t DEFAULT_MAP = default_map();

endpackage : fpd_tx_pkg

// >>> verilog/pixel_fifo.sv
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data_q,
  output logic out_valid_q,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("pixel_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic wr_en;
  logic rd_en;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign wr_en = in_valid && in_ready;
  assign rd_en = (count_q != '0) && (!out_valid_q || out_ready);

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (wr_en) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (rd_en) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      count_q <= count_q + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    end
  end

  // Read data registered; holds until taken
  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (rd_en) begin
      out_valid_q <= 1'b1;
      out_data_q <= mem_q[rd_ptr_q];
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

endmodule : pixel_fifo

// >>> verilog/flat_panel_serial_transmitter.sv
`timescale 1ns/1ps
module flat_panel_serial_transmitter #(
  parameter int LOCK_CYCLES = fpd_tx_pkg::LOCK_CYCLES,
  parameter int SLOT_DIV = fpd_tx_pkg::SLOT_DIV,
  parameter int FIFO_DEPTH = fpd_tx_pkg::FIFO_DEPTH,
  parameter fpd_tx_pkg::lane_map_t LANE_MAP = fpd_tx_pkg::DEFAULT_MAP
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Graphics controller side
  input wire logic pixel_clock_in,
  input wire fpd_tx_pkg::pixel_word_s parallel_word_in,
  input wire logic strobe_edge_select,
  input wire logic power_down_n,
  // Serial link side
  output fpd_tx_pkg::serial_link_s link_q,
  output fpd_tx_pkg::serial_link_s link_oe_n_q,
  // Status
  output logic link_active_q,
  output logic fifo_overflow_q
);
  localparam int SLOTS = fpd_tx_pkg::SLOTS;
  localparam int LANES = fpd_tx_pkg::LANES;
  localparam int WB = fpd_tx_pkg::WORD_BITS;
  localparam int PDD_BOUND = fpd_tx_pkg::PDD_CYCLES;

  if (LOCK_CYCLES < 1 || SLOT_DIV < 2 || SLOT_DIV > 255 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("flat_panel_serial_transmitter parameter out of range");
  end
  for (genvar i = 0; i < LANES * SLOTS; i++) begin : g_map_check
    if (LANE_MAP[i] >= WB) begin : g_bad_map
      $error("lane map entry names a missing input bit");
    end
  end

  fpd_tx_pkg::tx_state_e state_q;
  logic run;
  logic pclk_q;
  logic pclk_prev_q;
  logic edge_sel_q;
  logic pwr_on_q;
  logic [WB-1:0] in_word_q;
  logic capture;
  logic push;
  logic fifo_in_ready;
  logic [WB-1:0] fifo_data;
  logic fifo_valid;
  logic word_load;
  logic [31:0] lock_cnt_q;
  logic [7:0] div_cnt_q;
  logic [2:0] slot_q;
  logic slot_tick;
  logic [WB-1:0] word_q;
  logic [LANES-1:0] lane_bits;

  assign run = (state_q == fpd_tx_pkg::ST_RUN);

  // Input sampling
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pclk_q <= 1'b0;
      pclk_prev_q <= 1'b0;
      edge_sel_q <= 1'b0;
      pwr_on_q <= 1'b0;
      in_word_q <= '0;
    end else begin
      pclk_q <= pixel_clock_in;
      pclk_prev_q <= pclk_q;
      edge_sel_q <= strobe_edge_select;
      pwr_on_q <= power_down_n;
      in_word_q <= parallel_word_in;
    end
  end

  // Same word goes to the FIFO for either edge, so the line format never changes
  assign capture = edge_sel_q ? (pclk_q && !pclk_prev_q) : (!pclk_q && pclk_prev_q);
  assign push = capture && run;

  // Power and lock sequencing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= fpd_tx_pkg::ST_DOWN;
    end else begin
      case (state_q)
        fpd_tx_pkg::ST_DOWN: begin
          if (pwr_on_q) begin
            state_q <= fpd_tx_pkg::ST_LOCK;
          end
        end
        fpd_tx_pkg::ST_LOCK: begin
          if (!pwr_on_q) begin
            state_q <= fpd_tx_pkg::ST_DOWN;
          end else if (lock_cnt_q == 32'(LOCK_CYCLES - 1)) begin
            state_q <= fpd_tx_pkg::ST_RUN;
          end
        end
        fpd_tx_pkg::ST_RUN: begin
          if (!pwr_on_q) begin
            state_q <= fpd_tx_pkg::ST_DOWN;
          end
        end
        default: begin
          state_q <= fpd_tx_pkg::ST_DOWN;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || state_q != fpd_tx_pkg::ST_LOCK) begin
      lock_cnt_q <= '0;
    end else begin
      lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
    end
  end

  // Absorbs the skew between pixel capture and the slot divider
  pixel_fifo #(
    .WIDTH(WB),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset(reset || !run),
    .in_data(in_word_q),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data_q(fifo_data),
    .out_valid_q(fifo_valid),
    .out_ready(word_load)
  );

  // Host cannot be stalled; a lost word is flagged until power-down
  always_ff @(posedge core_clk) begin
    if (reset || !run) begin
      fifo_overflow_q <= 1'b0;
    end else if (push && !fifo_in_ready) begin
      fifo_overflow_q <= 1'b1;
    end
  end

  // Bit slot divider
  assign slot_tick = run && (div_cnt_q == 8'(SLOT_DIV - 1));
  assign word_load = slot_tick && (slot_q == 3'(SLOTS - 1));

  always_ff @(posedge core_clk) begin
    if (reset || !run) begin
      div_cnt_q <= '0;
      slot_q <= '0;
    end else if (slot_tick) begin
      div_cnt_q <= '0;
      slot_q <= (slot_q == 3'(SLOTS - 1)) ? 3'h0 : slot_q + 3'h1;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // Underrun sends an all-zero word rather than repeating stale pixels
  always_ff @(posedge core_clk) begin
    if (reset || !run) begin
      word_q <= '0;
    end else if (word_load) begin
      word_q <= fifo_valid ? fifo_data : '0;
    end
  end

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign lane_bits[l] = word_q[LANE_MAP[l * SLOTS + 32'(slot_q)]];
  end

  always_ff @(posedge core_clk) begin
    if (reset || !run) begin
      link_q <= '0;
    end else if (slot_tick) begin
      link_q.serial_lane_p <= lane_bits;
      link_q.serial_lane_n <= ~lane_bits;
      link_q.forwarded_clock_p <= fpd_tx_pkg::CLK_PATTERN[slot_q];
      link_q.forwarded_clock_n <= ~fpd_tx_pkg::CLK_PATTERN[slot_q];
    end else if (link_oe_n_q != '0) begin
      // Idle pairs complementary before the first slot; an enabled pair never sits at 0/0
      link_q.serial_lane_n <= '1;
      link_q.forwarded_clock_n <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      link_oe_n_q <= '1;
      link_active_q <= 1'b0;
    end else begin
      link_oe_n_q <= (run && pwr_on_q) ? '0 : '1;
      link_active_q <= run && pwr_on_q;
    end
  end

  AST_PDD_BOUND: assert property (@(posedge core_clk) disable iff (reset)
    $fell(power_down_n) |-> ##[1:PDD_BOUND] (link_oe_n_q == '1))
    else $error("outputs not released after power-down");

  AST_HIZ_HELD: assert property (@(posedge core_clk) disable iff (reset)
    (!power_down_n && !$past(power_down_n, 3)) |-> (link_oe_n_q == '1 && link_q == '0))
    else $error("outputs driven during power-down");

  AST_NO_DRIVE_BEFORE_LOCK: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == fpd_tx_pkg::ST_LOCK) |=> (link_oe_n_q == '1))
    else $error("link driven before lock");

  AST_LOCK_DONE: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == fpd_tx_pkg::ST_LOCK && pwr_on_q && lock_cnt_q == 32'(LOCK_CYCLES - 1))
    |=> (state_q == fpd_tx_pkg::ST_RUN) ##2 (link_oe_n_q == '0 || !pwr_on_q))
    else $error("lock time not honoured");

  AST_SLOT_WRAP: assert property (@(posedge core_clk) disable iff (reset)
    (slot_tick && slot_q == 3'h6) |=> (slot_q == 3'h0 && !slot_tick))
    else $error("slot counter did not wrap after slot 6");

  AST_CLK_SLOT0: assert property (@(posedge core_clk) disable iff (reset)
    (slot_tick && slot_q == 3'h0) |=> link_q.forwarded_clock_p && !link_q.forwarded_clock_n)
    else $error("forwarded clock low in slot 0");

  AST_CLK_SLOT4: assert property (@(posedge core_clk) disable iff (reset)
    (slot_tick && slot_q == 3'h4) |=> !link_q.forwarded_clock_p ##1 !link_q.forwarded_clock_p)
    else $error("forwarded clock high in slot 4");

  AST_DIFF_PAIR: assert property (@(posedge core_clk) disable iff (reset)
    (link_oe_n_q == '0) |-> (link_q.serial_lane_n == ~link_q.serial_lane_p))
    else $error("lane pair not complementary");

  AST_RISE_PUSH: assert property (@(posedge core_clk) disable iff (reset)
    (run && edge_sel_q && pclk_q && !pclk_prev_q) |-> push)
    else $error("rising edge capture missed");

  AST_FALL_IGNORED: assert property (@(posedge core_clk) disable iff (reset)
    (edge_sel_q && !pclk_q && pclk_prev_q) |-> !push)
    else $error("falling edge captured in rising mode");

  AST_LANE0_MAP: assert property (@(posedge core_clk) disable iff (reset)
    (slot_tick && !word_load) |=>
    (link_q.serial_lane_p[0] == $past(word_q[LANE_MAP[32'(slot_q)]])))
    else $error("lane 0 bit does not follow the lane map");

  AST_LOAD_AT_END: assert property (@(posedge core_clk) disable iff (reset)
    (word_load && fifo_valid) |=> (word_q == $past(fifo_data)))
    else $error("queued word not loaded at period end");

endmodule : flat_panel_serial_transmitter

// >>> test/panel_partner.sv
`timescale 1ns/1ps
module panel_partner #(
  parameter int SLOT_DIV = 4
) (
  // Clock
  input wire logic core_clk,
  // Pixel source controls
  input wire logic [7:0] half,
  input wire logic rise_mode,
  // Controller outputs
  output logic pixel_clock_in,
  output fpd_tx_pkg::pixel_word_s parallel_word_in,
  // Link from the transmitter
  input wire fpd_tx_pkg::serial_link_s link_q,
  input wire fpd_tx_pkg::serial_link_s link_oe_n_q,
  // Recovered words
  output logic [27:0] rx_word,
  output logic rx_stb,
  output int proto_errs
);
  logic [13:0] k = 14'h0001;
  logic [7:0] hc = 8'h00;
  logic fclk_prev = 1'b0;
  logic [27:0] acc = 28'h000_0000;
  int cnt = 100;

  initial begin
    pixel_clock_in = 1'b0;
    parallel_word_in = '0;
    rx_word = 28'h000_0000;
    rx_stb = 1'b0;
    proto_errs = 0;
  end

  // Word changes a few cycles after each pixel edge; the value seen at
  // the unselected edge is malformed, so a wrong capture edge shows up
  // Pixel rate scaled to the core clock, since the slot rate is fixed by SLOT_DIV
  always @(negedge core_clk) begin
    hc <= (hc >= half - 8'd1) ? 8'h00 : hc + 8'd1;
    if (hc >= half - 8'd1) begin
      pixel_clock_in <= ~pixel_clock_in;
    end
    if (hc == 8'd3) begin
      if (pixel_clock_in == rise_mode) begin
        parallel_word_in <= fpd_tx_pkg::pixel_word_s'({k, k});
      end else begin
        k <= k + 14'h0001;
        parallel_word_in <= fpd_tx_pkg::pixel_word_s'({k + 14'h0001, ~(k + 14'h0001)});
      end
    end
  end

  // Receiver framing: forwarded clock rise marks slot 0, mid-slot sampling
  always @(posedge core_clk) begin : rx_side
    int c;
    int s;
    c = (link_q.forwarded_clock_p && !fclk_prev) ? 0 : cnt + 1;
    s = c / SLOT_DIV;
    cnt <= c;
    fclk_prev <= link_q.forwarded_clock_p;
    rx_stb <= 1'b0;
    if (link_oe_n_q === '0 && c % SLOT_DIV == SLOT_DIV / 2 && s < 7) begin
      if (link_q.serial_lane_n !== ~link_q.serial_lane_p
          || link_q.forwarded_clock_n !== ~link_q.forwarded_clock_p
          || link_q.forwarded_clock_p !== (s < 4)) begin
        proto_errs <= proto_errs + 1;
      end
      for (int l = 0; l < 4; l++) begin
        acc[l * 7 + s] = link_q.serial_lane_p[l];
      end
      if (s == 6) begin
        rx_word <= acc;
        rx_stb <= 1'b1;
      end
    end
  end
endmodule : panel_partner

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int LOCK_CYC = 20;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic strobe_edge_select = 1'b1;
  logic power_down_n = 1'b0;
  logic [7:0] half = 8'd16;
  logic pixel_clock_in;
  fpd_tx_pkg::pixel_word_s parallel_word_in;
  fpd_tx_pkg::serial_link_s link_q;
  fpd_tx_pkg::serial_link_s link_oe_n_q;
  logic link_active_q;
  logic fifo_overflow_q;
  logic [27:0] rx_word;
  logic rx_stb;
  int proto_errs;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int rx_n = 0;
  logic chk_on = 1'b0;
  logic seq_on = 1'b1;
  logic have_last = 1'b0;
  logic [13:0] last_k = 14'h0000;

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  flat_panel_serial_transmitter #(.LOCK_CYCLES(LOCK_CYC)) DUT (
    .core_clk(core_clk),
    .reset(reset),
    .pixel_clock_in(pixel_clock_in),
    .parallel_word_in(parallel_word_in),
    .strobe_edge_select(strobe_edge_select),
    .power_down_n(power_down_n),
    .link_q(link_q),
    .link_oe_n_q(link_oe_n_q),
    .link_active_q(link_active_q),
    .fifo_overflow_q(fifo_overflow_q)
  );

  panel_partner partner (
    .core_clk(core_clk),
    .half(half),
    .rise_mode(strobe_edge_select),
    .pixel_clock_in(pixel_clock_in),
    .parallel_word_in(parallel_word_in),
    .link_q(link_q),
    .link_oe_n_q(link_oe_n_q),
    .rx_word(rx_word),
    .rx_stb(rx_stb),
    .proto_errs(proto_errs)
  );

  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // Underrun periods carry zero words and are skipped
  always @(posedge core_clk) begin : rx_check
    logic [13:0] ek;
    if (rx_stb && chk_on && rx_word !== 28'h000_0000) begin
      rx_n++;
      ek = (have_last && seq_on) ? last_k + 14'h0001 : rx_word[27:14];
      check(rx_word, {ek, ~ek});
      last_k = rx_word[27:14];
      have_last = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, cycles, 0);
      complete_run();
    end
  end

  task automatic t_lock;
    int n;
    n = 0;
    @(negedge core_clk);
    power_down_n = 1'b1;
    while (link_active_q !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    check(28'(n >= LOCK_CYC && n <= LOCK_CYC + 6), 28'h000_0001);
    check(28'(link_oe_n_q), 28'h000_0000);
    $display("test lock done");
  endtask : t_lock

  task automatic t_stream(input logic rise);
    int n0;
    @(negedge core_clk);
    strobe_edge_select = rise;
    chk_on = 1'b0;
    repeat (4 * 32) @(negedge core_clk);
    have_last = 1'b0;
    seq_on = 1'b1;
    n0 = rx_n;
    chk_on = 1'b1;
    repeat (14 * 32) @(negedge core_clk);
    check(28'(rx_n - n0 >= 10), 28'h000_0001);
    check(28'(proto_errs), 28'h000_0000);
    $display("test stream done, rising %0d", rise);
  endtask : t_stream

  // Pixel rate above the word rate fills the buffer until it refuses
  task automatic t_overflow;
    int n;
    n = 0;
    @(negedge core_clk);
    seq_on = 1'b0;
    half = 8'd6;
    while (fifo_overflow_q !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    check(28'(fifo_overflow_q), 28'h000_0001);
    check(28'(n > 150), 28'h000_0001);
    half = 8'd64;
    repeat (800) @(negedge core_clk);
    check(28'(fifo_overflow_q), 28'h000_0001);
    half = 8'd16;
    $display("test overflow done");
  endtask : t_overflow

  task automatic t_power_down;
    int n;
    n = 0;
    @(negedge core_clk);
    chk_on = 1'b0;
    power_down_n = 1'b0;
    while (link_oe_n_q !== '1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    check(28'(n <= fpd_tx_pkg::PDD_CYCLES), 28'h000_0001);
    repeat (50) @(negedge core_clk);
    check({link_q, link_oe_n_q, link_active_q, fifo_overflow_q, 6'h00},
          {10'h000, 10'h3ff, 8'h00});
    $display("test power down done");
  endtask : t_power_down

  initial begin
    repeat (4) @(negedge core_clk);
    check({link_q, link_oe_n_q, link_active_q, fifo_overflow_q, 6'h00},
          {10'h000, 10'h3ff, 8'h00});
    reset = 1'b0;
    $display("test reset done");
    t_lock();
    t_stream(1'b1);
    t_stream(1'b0);
    t_overflow();
    t_stream(1'b1);
    t_power_down();
    t_lock();
    t_stream(1'b0);
    complete_run();
  end
endmodule : tb_top
